// >>> rtl/rfb_top.sv
// rfb_top: rf bias, front end, matching, power and pll test register bank
// assumes an axi4-lite master on MCLK_I and calibration logic on the same clock
//
// Added by the designer: register access over AXI4-Lite.
`default_nettype none
module rfb_top
  import rfb_pkg::*;
(
  // clock and reset
  input  wire logic                       MCLK_I,
  input  wire logic                       RST_I,
  // axi4-lite write address and data
  input  wire logic [rfb_pkg::ADDR_W-1:0] AWADDR_I,
  input  wire logic                       AWVALID_I,
  output logic                            AWREADY_O,
  input  wire logic [rfb_pkg::DATA_W-1:0] WDATA_I,
  input  wire logic [3:0]                 WSTRB_I,
  input  wire logic                       WVALID_I,
  output logic                            WREADY_O,
  // axi4-lite write response
  output logic [1:0]                      BRESP_O,
  output logic                            BVALID_O,
  input  wire logic                       BREADY_I,
  // axi4-lite read
  input  wire logic [rfb_pkg::ADDR_W-1:0] ARADDR_I,
  input  wire logic                       ARVALID_I,
  output logic                            ARREADY_O,
  output logic [rfb_pkg::DATA_W-1:0]      RDATA_O,
  output logic [1:0]                      RRESP_O,
  output logic                            RVALID_O,
  input  wire logic                       RREADY_I,
  // calibration engine results
  input  wire logic                       CAL_STORE_A_I,
  input  wire logic                       CAL_STORE_B_I,
  input  wire logic [rfb_pkg::NIB_W-1:0]  CAL_OSC_ARRAY_I,
  input  wire logic [rfb_pkg::PUMP_W-1:0] CAL_PUMP_CURRENT_I,
  input  wire logic [rfb_pkg::NIB_W-1:0]  CAL_DAC_I,
  // bias controls
  output logic [rfb_pkg::NIB_W-1:0]       OSC_CORE_BIAS_O,
  output logic [rfb_pkg::PAIR_W-1:0]      LOCAL_OSC_BUFFER_BIAS_O,
  output logic [rfb_pkg::PAIR_W-1:0]      AMP_BUFFER_BIAS_O,
  // front end controls
  output logic                            FOLLOWER_HIGH_CURRENT_O,
  output logic [rfb_pkg::PAIR_W-1:0]      LOW_NOISE_AMP_BIAS_O,
  output logic                            MIXER_TO_SHARED_ANALOG_PIN_O,
  output logic                            SIGNAL_STRENGTH_CONNECT_O,
  // matching and power arrays
  output logic [rfb_pkg::NIB_W-1:0]       RX_MATCH_CAP_O,
  output logic [rfb_pkg::NIB_W-1:0]       TX_MATCH_CAP_O,
  output logic [rfb_pkg::NIB_W-1:0]       HIGH_ARRAY_POWER_O,
  output logic [rfb_pkg::NIB_W-1:0]       LOW_ARRAY_POWER_O,
  // synthesizer applied values
  output logic                            FREQ_BANK_SEL_O,
  output logic                            LOOP_OPEN_O,
  output logic [rfb_pkg::NIB_W-1:0]       CAL_DAC_APPLIED_O,
  output logic [rfb_pkg::NIB_W-1:0]       APPLIED_OSC_ARRAY_O,
  output logic [rfb_pkg::PUMP_W-1:0]      PUMP_CURRENT_APPLIED_O
);
  import rfb_pkg::*;

  typedef struct packed {
    logic [7:0]            bias;
    logic [FE_STORE_W-1:0] front;
    logic [LOOP_W-1:0]     loop;
    logic [7:0]            tune;
    logic [7:0]            power;
    logic                  bank_sel;
  } rfb_top_state_t;

  rfb_top_state_t q, d;
  rfb_reg_if      rif ();

  logic [NIB_W-1:0]  dac_now;
  logic [NIB_W-1:0]  osc_now;
  logic [PUMP_W-1:0] pump_now;

  ////////////////////////////////////////////////////////////////////////////
  rfb_axil_slave i_rfb_axil_slave (
    .clk_i     (MCLK_I),
    .rst_i     (RST_I),
    .awaddr_i  (AWADDR_I),
    .awvalid_i (AWVALID_I),
    .awready_o (AWREADY_O),
    .wdata_i   (WDATA_I),
    .wstrb_i   (WSTRB_I),
    .wvalid_i  (WVALID_I),
    .wready_o  (WREADY_O),
    .bresp_o   (BRESP_O),
    .bvalid_o  (BVALID_O),
    .bready_i  (BREADY_I),
    .araddr_i  (ARADDR_I),
    .arvalid_i (ARVALID_I),
    .arready_o (ARREADY_O),
    .rdata_o   (RDATA_O),
    .rresp_o   (RRESP_O),
    .rvalid_o  (RVALID_O),
    .rready_i  (RREADY_I),
    .rif       (rif.slv)
  );

  rfb_synth_ctl i_rfb_synth_ctl (
    .clk_i       (MCLK_I),
    .rst_i       (RST_I),
    .loop_open_i (q.loop[LOOP_OPEN_BIT]),
    .open_dac_i  (q.loop[LOOP_DAC_LSB +: NIB_W]),
    .bank_sel_i  (q.bank_sel),
    .store_a_i   (CAL_STORE_A_I),
    .store_b_i   (CAL_STORE_B_I),
    .cal_osc_i   (CAL_OSC_ARRAY_I),
    .cal_pump_i  (CAL_PUMP_CURRENT_I),
    .cal_dac_i   (CAL_DAC_I),
    .loop_open_o (LOOP_OPEN_O),
    .dac_o       (dac_now),
    .osc_o       (osc_now),
    .pump_o      (pump_now)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read decode; unmapped indices answer slverr
  always_comb begin
    rif.rd_data = 8'h00;
    rif.rd_ok   = 1'b1;
    case (rif.rd_idx)
      IDX_BIAS:      rif.rd_data = q.bias;
      IDX_FRONT:     rif.rd_data = {2'h0, q.front, 1'h0};
      IDX_TUNE:      rif.rd_data = q.tune;
      IDX_POWER:     rif.rd_data = q.power;
      IDX_BANK:      rif.rd_data = {7'h00, q.bank_sel};
      IDX_LOOP:      rif.rd_data = {3'h0, q.loop};
      IDX_OSC_STAT:  rif.rd_data = {4'h0, osc_now};
      IDX_DAC_STAT:  rif.rd_data = {4'h0, dac_now};
      IDX_PUMP_STAT: rif.rd_data = {3'h0, pump_now};
      default:       rif.rd_ok   = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode; status writes are accepted and dropped
  always_comb begin
    d         = q;
    rif.wr_ok = 1'b1;
    case (rif.wr_idx)
      IDX_BIAS, IDX_FRONT, IDX_TUNE, IDX_POWER, IDX_BANK, IDX_LOOP,
      IDX_OSC_STAT, IDX_DAC_STAT, IDX_PUMP_STAT: rif.wr_ok = 1'b1;
      default: rif.wr_ok = 1'b0;
    endcase
    if (rif.wr_en && rif.wr_be) begin
      case (rif.wr_idx)
        IDX_BIAS: d.bias = rif.wr_data;
        // reserved bits 7:6 and 0 are not kept
        IDX_FRONT: d.front = rif.wr_data[FE_STORE_LSB +: FE_STORE_W];
        IDX_TUNE: d.tune = rif.wr_data;
        IDX_POWER: d.power = rif.wr_data;
        IDX_BANK: d.bank_sel = rif.wr_data[0];
        // loop open bit and open dac
        IDX_LOOP: d.loop = rif.wr_data[LOOP_W-1:0];
        default: d = q;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      q.bias     <= RST_BIAS;
      q.front    <= RST_FRONT;
      q.loop     <= RST_LOOP;
      q.tune     <= RST_TUNE;
      q.power    <= RST_POWER;
      q.bank_sel <= 1'b0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register fields to outputs; synthesizer values passed through
  assign OSC_CORE_BIAS_O         = q.bias[BIAS_OSC_LSB +: NIB_W];
  assign LOCAL_OSC_BUFFER_BIAS_O = q.bias[BIAS_LO_LSB +: PAIR_W];
  assign AMP_BUFFER_BIAS_O       = q.bias[BIAS_AMP_LSB +: PAIR_W];
  assign FOLLOWER_HIGH_CURRENT_O = q.front[FE_FOLLOW_BIT - FE_STORE_LSB];
  assign LOW_NOISE_AMP_BIAS_O    = q.front[FE_LNA_LSB - FE_STORE_LSB +: PAIR_W];
  assign MIXER_TO_SHARED_ANALOG_PIN_O = q.front[FE_MIXER_BIT - FE_STORE_LSB];
  assign SIGNAL_STRENGTH_CONNECT_O = q.front[FE_SIGSTR_BIT - FE_STORE_LSB];
  assign RX_MATCH_CAP_O          = q.tune[TUNE_RX_LSB +: NIB_W];
  assign TX_MATCH_CAP_O          = q.tune[TUNE_TX_LSB +: NIB_W];
  assign HIGH_ARRAY_POWER_O      = q.power[PWR_HIGH_LSB +: NIB_W];
  assign LOW_ARRAY_POWER_O       = q.power[PWR_LOW_LSB +: NIB_W];
  assign FREQ_BANK_SEL_O         = q.bank_sel;
  assign CAL_DAC_APPLIED_O       = dac_now;
  assign APPLIED_OSC_ARRAY_O     = osc_now;
  assign PUMP_CURRENT_APPLIED_O  = pump_now;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  sequence s_wr(logic [IDX_W-1:0] idx);
    rif.wr_en && rif.wr_be && rif.wr_idx == idx;
  endsequence

  a_loop_open_out: assert property (
    s_wr(IDX_LOOP) |=> ##1 LOOP_OPEN_O == $past(rif.wr_data[LOOP_OPEN_BIT], 2))
    else $error("loop open bit not reaching synthesizer");
  a_pump_read: assert property (
    rif.rd_en && rif.rd_idx == IDX_PUMP_STAT
      |-> rif.rd_data[7:5] == 3'h0 && rif.rd_data[4:0] == PUMP_CURRENT_APPLIED_O)
    else $error("pump status read wrong");
  a_dac_read: assert property (
    rif.rd_en && rif.rd_idx == IDX_DAC_STAT
      |-> rif.rd_data == {4'h0, CAL_DAC_APPLIED_O})
    else $error("dac status read wrong");
  a_osc_read: assert property (
    rif.rd_en && rif.rd_idx == IDX_OSC_STAT
      |-> rif.rd_data == {4'h0, APPLIED_OSC_ARRAY_O})
    else $error("osc array status read wrong");
  a_bias_fields: assert property (
    s_wr(IDX_BIAS) |=> {OSC_CORE_BIAS_O, LOCAL_OSC_BUFFER_BIAS_O, AMP_BUFFER_BIAS_O}
                        == $past(rif.wr_data))
    else $error("bias fields not updated");
  a_frontend_fields: assert property (
    s_wr(IDX_FRONT) |=> {FOLLOWER_HIGH_CURRENT_O, LOW_NOISE_AMP_BIAS_O,
                         MIXER_TO_SHARED_ANALOG_PIN_O, SIGNAL_STRENGTH_CONNECT_O}
                        == $past(rif.wr_data[5:1]))
    else $error("front end fields not updated");
  a_frontend_rsvd: assert property (
    rif.rd_en && rif.rd_idx == IDX_FRONT |-> rif.rd_data[7:6] == 2'h0 && !rif.rd_data[0])
    else $error("front end reserved bits read nonzero");
  a_tune_fields: assert property (
    s_wr(IDX_TUNE) |=> RX_MATCH_CAP_O == $past(rif.wr_data[7:4])
                       && TX_MATCH_CAP_O == $past(rif.wr_data[3:0]))
    else $error("match fields not split 7:4 and 3:0");
  a_power_fields: assert property (
    s_wr(IDX_POWER) |=> {HIGH_ARRAY_POWER_O, LOW_ARRAY_POWER_O} == $past(rif.wr_data))
    else $error("power array nibbles wrong");
  a_write_resp: assert property (
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O)
    else $error("write response not after two cycles");
  a_read_resp: assert property (
    ARVALID_I && ARREADY_O |=> RVALID_O && RDATA_O[7:0] == $past(rif.rd_data))
    else $error("read data not returned next cycle");
  a_strobe_mask: assert property (
    rif.wr_en && !rif.wr_be |=> $stable(q))
    else $error("write with byte strobe low changed a register");
endmodule
`default_nettype wire

// >>> rtl/rfb_pkg.sv
// rfb_pkg: register indices, field layout, reset values for the rf bias bank
// assumes byte address = 4 * register index, data in the low byte of the word
`default_nettype none
package rfb_pkg;
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 10;
  localparam int IDX_LSB = 2;

  // register indices (byte address is four times these)
  localparam logic [IDX_W-1:0] IDX_BANK      = 10'h0d8;
  localparam logic [IDX_W-1:0] IDX_TUNE      = 10'h0dc;
  localparam logic [IDX_W-1:0] IDX_BIAS      = 10'h0e1;
  localparam logic [IDX_W-1:0] IDX_POWER     = 10'h0e2;
  localparam logic [IDX_W-1:0] IDX_FRONT     = 10'h0ee;
  localparam logic [IDX_W-1:0] IDX_OSC_STAT  = 10'h0f9;
  localparam logic [IDX_W-1:0] IDX_DAC_STAT  = 10'h0fa;
  localparam logic [IDX_W-1:0] IDX_PUMP_STAT = 10'h0fb;
  localparam logic [IDX_W-1:0] IDX_LOOP      = 10'h0fc;

  // field positions
  localparam int BIAS_OSC_LSB  = 4;
  localparam int BIAS_LO_LSB   = 2;
  localparam int BIAS_AMP_LSB  = 0;
  localparam int FE_FOLLOW_BIT = 5;
  localparam int FE_LNA_LSB    = 3;
  localparam int FE_MIXER_BIT  = 2;
  localparam int FE_SIGSTR_BIT = 1;
  localparam int FE_STORE_LSB  = 1;
  localparam int FE_STORE_W    = 5;
  localparam int LOOP_OPEN_BIT = 4;
  localparam int LOOP_DAC_LSB  = 0;
  localparam int TUNE_RX_LSB   = 4;
  localparam int TUNE_TX_LSB   = 0;
  localparam int PWR_HIGH_LSB  = 4;
  localparam int PWR_LOW_LSB   = 0;
  localparam int NIB_W         = 4;
  localparam int PAIR_W        = 2;
  localparam int PUMP_W        = 5;
  localparam int LOOP_W        = 5;

  // reset values
  localparam logic [7:0]        RST_BIAS  = 8'h00;
  localparam logic [FE_STORE_W-1:0] RST_FRONT = 5'h00;
  localparam logic [LOOP_W-1:0] RST_LOOP  = 5'h00;
  localparam logic [7:0]        RST_TUNE  = 8'h00;
  localparam logic [7:0]        RST_POWER = 8'h00;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// >>> rtl/rfb_reg_if.sv
// rfb_reg_if: register access strobes between the bus slave and the bank
// assumes one clock; wr_en and rd_en are single-cycle pulses
`default_nettype none
interface rfb_reg_if;
  logic                      wr_en;
  logic [rfb_pkg::IDX_W-1:0] wr_idx;
  logic [7:0]                wr_data;
  logic                      wr_be;
  logic                      wr_ok;
  logic                      rd_en;
  logic [rfb_pkg::IDX_W-1:0] rd_idx;
  logic [7:0]                rd_data;
  logic                      rd_ok;
  modport slv (output wr_en, wr_idx, wr_data, wr_be, rd_en, rd_idx,
               input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_idx, wr_data, wr_be, rd_en, rd_idx,
                output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

// >>> rtl/rfb_axil_slave.sv
// rfb_axil_slave: axi4-lite slave turning bus transfers into register strobes
// assumes the bank answers rd_data/rd_ok and wr_ok combinationally
`default_nettype none
module rfb_axil_slave
  import rfb_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // write channels
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [3:0]        wstrb_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  output logic [1:0]             bresp_o,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  // read channels
  input  wire logic [ADDR_W-1:0] araddr_i,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [1:0]             rresp_o,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  // register side
  rfb_reg_if.slv                 rif
);
  typedef struct packed {
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [7:0]       rdata;
    logic [1:0]       rresp;
    logic             aw_have;
    logic             w_have;
    logic [IDX_W-1:0] awidx;
    logic [7:0]       wdata;
    logic             wbe;
  } rfb_slv_state_t;

  rfb_slv_state_t q, d;
  logic commit;

  always_comb begin
    d           = q;
    commit      = q.aw_have && q.w_have && !q.bvalid;
    rif.wr_en   = commit;
    rif.wr_idx  = q.awidx;
    rif.wr_data = q.wdata;
    rif.wr_be   = q.wbe;
    rif.rd_en   = arvalid_i && q.arready;
    rif.rd_idx  = araddr_i[IDX_LSB +: IDX_W];
    if (awvalid_i && q.awready) begin
      d.aw_have = 1'b1;
      d.awidx   = awaddr_i[IDX_LSB +: IDX_W];
    end
    if (wvalid_i && q.wready) begin
      d.w_have = 1'b1;
      d.wdata  = wdata_i[7:0];
      d.wbe    = wstrb_i[0];
    end
    if (q.bvalid && bready_i) begin
      d.bvalid = 1'b0;
    end
    if (commit) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rvalid && rready_i) begin
      d.rvalid = 1'b0;
    end
    if (rif.rd_en) begin
      d.rvalid = 1'b1;
      d.rdata  = rif.rd_data;
      d.rresp  = rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign awready_o = q.awready;
  assign wready_o  = q.wready;
  assign bvalid_o  = q.bvalid;
  assign bresp_o   = q.bresp;
  assign arready_o = q.arready;
  assign rvalid_o  = q.rvalid;
  assign rdata_o   = {24'h000000, q.rdata};
  assign rresp_o   = q.rresp;
endmodule
`default_nettype wire

// >>> rtl/rfb_synth_ctl.sv
// rfb_synth_ctl: calibration result copies per frequency bank and dac override
// assumes calibration inputs come from logic on the same clock
`default_nettype none
module rfb_synth_ctl
  import rfb_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // control from the register bank
  input  wire logic              loop_open_i,
  input  wire logic [NIB_W-1:0]  open_dac_i,
  input  wire logic              bank_sel_i,
  // calibration engine
  input  wire logic              store_a_i,
  input  wire logic              store_b_i,
  input  wire logic [NIB_W-1:0]  cal_osc_i,
  input  wire logic [PUMP_W-1:0] cal_pump_i,
  input  wire logic [NIB_W-1:0]  cal_dac_i,
  // applied values
  output logic                   loop_open_o,
  output logic [NIB_W-1:0]       dac_o,
  output logic [NIB_W-1:0]       osc_o,
  output logic [PUMP_W-1:0]      pump_o
);
  typedef struct packed {
    logic [NIB_W-1:0]  osc_a;
    logic [NIB_W-1:0]  osc_b;
    logic [PUMP_W-1:0] pump_a;
    logic [PUMP_W-1:0] pump_b;
    logic              loop_open;
    logic [NIB_W-1:0]  dac;
    logic [NIB_W-1:0]  osc_cur;
    logic [PUMP_W-1:0] pump_cur;
  } rfb_syn_state_t;

  rfb_syn_state_t q, d;

  always_comb begin
    d = q;
    if (store_a_i) begin
      d.osc_a  = cal_osc_i;
      d.pump_a = cal_pump_i;
    end
    if (store_b_i) begin
      d.osc_b  = cal_osc_i;
      d.pump_b = cal_pump_i;
    end
    // selected copy registered: outputs leave a flop, bank switch lags a cycle
    d.osc_cur   = bank_sel_i ? d.osc_b : d.osc_a;
    d.pump_cur  = bank_sel_i ? d.pump_b : d.pump_a;
    d.loop_open = loop_open_i;
    d.dac       = loop_open_i ? open_dac_i : cal_dac_i;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign loop_open_o = q.loop_open;
  assign dac_o       = q.dac;
  assign osc_o       = q.osc_cur;
  assign pump_o      = q.pump_cur;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_dac_override: assert property (
    loop_open_i |=> loop_open_o && dac_o == $past(open_dac_i))
    else $error("open-loop dac value not applied");
  // sampled reset keeps the release edge out
  a_dac_closed: assert property (
    !rst_i && !loop_open_i |=> !loop_open_o && dac_o == $past(cal_dac_i))
    else $error("calibration dac not applied with loop closed");
  a_bank_copy_b: assert property (
    store_b_i && !store_a_i |=> q.osc_b == $past(cal_osc_i) && $stable(q.osc_a)
                                && q.pump_b == $past(cal_pump_i))
    else $error("bank b copy not stored alone");
endmodule
`default_nettype wire

// >>> verification/rf_bias_and_test_registers_tb.sv
// rf_bias_and_test_registers_tb: directed bench for the rf bias register bank
// assumes rfb_top behind an axi4-lite slave, calibration stores on the same clock
`default_nettype none
module rf_bias_and_test_registers_tb
  import rfb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [3:0]  be = 4'h1;
  logic        st_a = 1'h0, st_b = 1'h0;
  logic [3:0]  c_osc = 4'h0, c_dac = 4'h9;
  logic [4:0]  c_pump = 5'h0;
  logic        awready, wready, bvalid, arready, rvalid, fol, mix, sig, bank, lopen;
  logic [1:0]  bresp, rresp, lo, amp, lna;
  logic [31:0] rdata;
  logic [3:0]  osc, rxm, txm, hi, low, dac, aosc;
  logic [4:0]  pump;
  int          errors = 0, n_checks = 0, cyc = 0;

  rfb_top i_rfb_top (
    .MCLK_I(clk), .RST_I(rst),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
    .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .CAL_STORE_A_I(st_a), .CAL_STORE_B_I(st_b), .CAL_OSC_ARRAY_I(c_osc),
    .CAL_PUMP_CURRENT_I(c_pump), .CAL_DAC_I(c_dac),
    .OSC_CORE_BIAS_O(osc), .LOCAL_OSC_BUFFER_BIAS_O(lo), .AMP_BUFFER_BIAS_O(amp),
    .FOLLOWER_HIGH_CURRENT_O(fol), .LOW_NOISE_AMP_BIAS_O(lna),
    .MIXER_TO_SHARED_ANALOG_PIN_O(mix), .SIGNAL_STRENGTH_CONNECT_O(sig),
    .RX_MATCH_CAP_O(rxm), .TX_MATCH_CAP_O(txm),
    .HIGH_ARRAY_POWER_O(hi), .LOW_ARRAY_POWER_O(low),
    .FREQ_BANK_SEL_O(bank), .LOOP_OPEN_O(lopen), .CAL_DAC_APPLIED_O(dac),
    .APPLIED_OSC_ARRAY_O(aosc), .PUMP_CURRENT_APPLIED_O(pump)
  );

  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // extra edges at the end let the delayed loop/dac outputs settle
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= be;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk(32'(bresp), 32'(er));
    repeat (2) @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge clk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(32'(rresp), 32'(er));
    chk(rdata, {24'h0, exp});
  endtask

  task automatic cal(input logic to_a, input logic [3:0] o, input logic [4:0] p);
    @(posedge clk);
    st_a   <= to_a;
    st_b   <= ~to_a;
    c_osc  <= o;
    c_pump <= p;
    @(posedge clk);
    st_a <= 1'h0;
    st_b <= 1'h0;
  endtask

  task automatic stop_test;
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // hang guard, the directed run needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    rd({IDX_BIAS, 2'h0}, 8'h00, RESP_OKAY);
    wr({IDX_BIAS, 2'h0}, 8'hf4, RESP_OKAY);
    chk(32'(osc), 32'hf);
    chk(32'(lo), 32'h1);
    chk(32'(amp), 32'h0);
    rd({IDX_BIAS, 2'h0}, 8'hf4, RESP_OKAY);
    wr({IDX_BIAS, 2'h0}, 8'h4b, RESP_OKAY);
    chk(32'(osc), 32'h4);
    chk(32'(lo), 32'h2);
    chk(32'(amp), 32'h3);
    // reserved front end bits kept at zero by software
    wr({IDX_FRONT, 2'h0}, 8'h36, RESP_OKAY);
    chk(32'(fol), 32'h1);
    chk(32'(lna), 32'h2);
    chk(32'(mix), 32'h1);
    chk(32'(sig), 32'h1);
    rd({IDX_FRONT, 2'h0}, 8'h36, RESP_OKAY);
    wr({IDX_FRONT, 2'h0}, 8'h08, RESP_OKAY);
    chk(32'(fol), 32'h0);
    chk(32'(lna), 32'h1);
    chk(32'(mix), 32'h0);
    chk(32'(sig), 32'h0);
    wr({IDX_TUNE, 2'h0}, 8'hc3, RESP_OKAY);
    chk(32'(rxm), 32'hc);
    chk(32'(txm), 32'h3);
    rd({IDX_TUNE, 2'h0}, 8'hc3, RESP_OKAY);
    wr({IDX_POWER, 2'h0}, 8'h5a, RESP_OKAY);
    chk(32'(hi), 32'h5);
    chk(32'(low), 32'ha);
    wr({IDX_POWER, 2'h0}, 8'h00, RESP_OKAY);
    chk({24'h0, hi, low}, 32'h0);
    wr({IDX_LOOP, 2'h0}, 8'hff, RESP_OKAY);
    chk(32'(lopen), 32'h1);
    chk(32'(dac), 32'hf);
    rd({IDX_LOOP, 2'h0}, 8'h1f, RESP_OKAY);
    rd({IDX_DAC_STAT, 2'h0}, 8'h0f, RESP_OKAY);
    wr({IDX_LOOP, 2'h0}, 8'h07, RESP_OKAY);
    chk(32'(lopen), 32'h0);
    chk(32'(dac), 32'h9);
    rd({IDX_DAC_STAT, 2'h0}, 8'h09, RESP_OKAY);
    cal(1'h1, 4'h5, 5'h13);
    cal(1'h0, 4'ha, 5'h0c);
    wr({IDX_BANK, 2'h0}, 8'h00, RESP_OKAY);
    chk(32'(bank), 32'h0);
    chk(32'(aosc), 32'h5);
    chk(32'(pump), 32'h13);
    rd({IDX_OSC_STAT, 2'h0}, 8'h05, RESP_OKAY);
    rd({IDX_PUMP_STAT, 2'h0}, 8'h13, RESP_OKAY);
    wr({IDX_BANK, 2'h0}, 8'h01, RESP_OKAY);
    chk(32'(bank), 32'h1);
    chk(32'(aosc), 32'ha);
    chk(32'(pump), 32'h0c);
    wr({IDX_OSC_STAT, 2'h0}, 8'hff, RESP_OKAY);
    wr({IDX_PUMP_STAT, 2'h0}, 8'hff, RESP_OKAY);
    rd({IDX_OSC_STAT, 2'h0}, 8'h0a, RESP_OKAY);
    rd({IDX_PUMP_STAT, 2'h0}, 8'h0c, RESP_OKAY);
    wr(12'h004, 8'h55, RESP_SLVERR);
    rd(12'h004, 8'h00, RESP_SLVERR);
    // byte strobe low: answered okay, register untouched
    be = 4'h0;
    wr({IDX_BIAS, 2'h0}, 8'h00, RESP_OKAY);
    be = 4'h1;
    rd({IDX_BIAS, 2'h0}, 8'h4b, RESP_OKAY);
    stop_test();
  end
endmodule
`default_nettype wire
